// >>> rsfs_top.sv
// Reverse buck control, fault supervision, status pins and registers
//
// Function
// - Status pin released: no input, standby, faults
// - Charging: status pin blinks 1Hz, half duty
// - Reverse mode on mode 0x0A or pin
// - Three-bit current limit, four settings
// - Current direction reported out in reverse mode
// - Fault detail latched until status read
// - Overload 37.5ms: flag, not ok, detail 01
// - Overload 60ms stops; 300ms off, repeats
// - Input undervoltage: stop, flag, detail 00
// - Input overvoltage: stop, flag, detail 10
// - Under/overvoltage stop retries after 300ms
// - Start from off only below threshold, discharge first; hiccup retries restart without either
// - Reverse flag, mask and ok status reachable
// - System undervoltage: flag now, 8ms shutdown
// - System overvoltage: flag and shutdown now
// - Thermal shutdown, re-enable after cooling
// - Interrupt pin low on unmasked pending flag
// - Reverse power-good only inside voltage window
`timescale 1ns/1ps
module rsfs_top
   import rsfs_pkg::*;
#(
   parameter int P_OVLD_FLAG_CYC   = OVLD_FLAG_CYC,
   parameter int P_OVLD_STOP_CYC   = OVLD_STOP_CYC,
   parameter int P_OFF_TIME_CYC    = OFF_TIME_CYC,
   parameter int P_SYS_UV_CYC      = SYS_UV_CYC,
   parameter int P_BLINK_HALF_CYC  = BLINK_HALF_CYC,
   parameter int P_START_BLANK_CYC = START_BLANK_CYC
) (
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic      [7:0] rdata,
   input  wire logic       reverse_enable_pin,
   input  wire logic       ovld_cmp,
   input  wire logic       in_uv_cmp,
   input  wire logic       in_ov_cmp,
   input  wire logic       sys_uv_cmp,
   input  wire logic       sys_ov_cmp,
   input  wire logic       die_hot_cmp,
   input  wire logic       die_cool_cmp,
   input  wire logic       input_valid,
   input  wire logic [2:0] chg_state,
   output logic            switching_en,
   output logic            discharge_en,
   output logic            current_out_dir,
   output logic      [1:0] reverse_current_limit_field,
   output logic            skip_disable_bit,
   output logic            shutdown,
   output logic            stat_oe,
   output logic            power_good_out_n_oe,
   output logic            interrupt_out_n_oe
);
   localparam logic [CNT_W-1:0] C_FLAG  = CNT_W'(P_OVLD_FLAG_CYC - 1);
   localparam logic [CNT_W-1:0] C_STOP  = CNT_W'(P_OVLD_STOP_CYC - 1);
   localparam logic [CNT_W-1:0] C_OFF   = CNT_W'(P_OFF_TIME_CYC - 1);
   localparam logic [CNT_W-1:0] C_SUV   = CNT_W'(P_SYS_UV_CYC);
   localparam logic [CNT_W-1:0] C_BLINK = CNT_W'(P_BLINK_HALF_CYC - 1);
   localparam logic [CNT_W-1:0] C_BLANK = CNT_W'(P_START_BLANK_CYC);

   typedef struct packed {
      rsfs_rev_t        rs;
      logic [NFLAG-1:0] flags;
      logic [NFLAG-1:0] mask;
      logic [3:0]       mode;
      logic             stby;
      logic             skip;
      logic [2:0]       ilim;
      logic [1:0]       dtl;
      logic             dtl_held;
      logic             therm;
      logic             shdn;
      logic             blink;
      logic             sw_en;
      logic             disch_en;
      logic             dir_out;
      logic             ok;
      logic             pg_oe;
      logic             irq_oe;
      logic             stat_oe;
      logic [1:0]       ilim_sel;
      logic [7:0]       rdata;
   } rsfs_state_t;

   rsfs_state_t      s_ff;
   rsfs_state_t      nxt_s;
   logic [NSYNC-1:0] sin;
   logic [CNT_W-1:0] c_ovld;
   logic [CNT_W-1:0] c_st;
   logic [CNT_W-1:0] c_suv;
   logic [CNT_W-1:0] c_blink;
   logic             req;
   logic             shut;
   logic             ev_rev;
   logic [1:0]       ev_dtl;
   logic             rd_flags;
   logic             rd_stat;
   logic             blinking;
   logic             stat_hiz;
   logic             ovld_run;

   // Comparators and the enable pin come from outside the clock domain
   rsfs_sync #(.W(NSYNC)) u_sync (
      .clock (clock),
      .rst   (rst),
      .din   ({die_cool_cmp, die_hot_cmp, sys_ov_cmp, sys_uv_cmp,
                in_ov_cmp, in_uv_cmp, ovld_cmp, reverse_enable_pin}),
      .dout  (sin)
   );

   assign ovld_run = (s_ff.rs == RS_RUN) && sin[SI_OVLD];
   assign blinking = (chg_state == CHG_TRICKLE) || (chg_state == CHG_PRECHG) ||
                     (chg_state == CHG_FAST);

   rsfs_cnt u_c_ovld  (.clock(clock), .rst(rst), .clr(!ovld_run),           .count(c_ovld));
   rsfs_cnt u_c_st    (.clock(clock), .rst(rst), .clr(nxt_s.rs != s_ff.rs), .count(c_st));
   rsfs_cnt u_c_suv   (.clock(clock), .rst(rst), .clr(!sin[SI_SUV]),        .count(c_suv));
   rsfs_cnt u_c_blink (.clock(clock), .rst(rst),
                       .clr(!blinking || (c_blink == C_BLINK)),             .count(c_blink));

   always_comb begin
      nxt_s    = s_ff;
      req      = (s_ff.mode == MODE_REVERSE) || sin[SI_PIN];
      rd_flags = rd && (addr == REG_FLAGS);
      rd_stat  = rd && (addr == REG_STATUS);
      ev_rev   = 1'b0;
      ev_dtl   = DTL_NONE;

      // Thermal latch keeps off until the cool comparator trips
      if (sin[SI_HOT]) begin
         nxt_s.therm = 1'b1;
      end else if (sin[SI_COOL]) begin
         nxt_s.therm = 1'b0;
      end
      shut = sin[SI_SOV] || (sin[SI_SUV] && (c_suv >= C_SUV)) || s_ff.therm;
      nxt_s.shdn = shut;

      unique case (s_ff.rs)
         RS_OFF: begin
            if (req) begin
               nxt_s.rs = sin[SI_UV] ? RS_RUN : RS_DISCH;
            end
         end
         RS_DISCH: begin
            if (sin[SI_UV]) begin
               nxt_s.rs = RS_RUN;
            end
         end
         RS_RUN: begin
            // Undervoltage blanked at start: the port rises from below threshold
            if (sin[SI_UV] && (c_st >= C_BLANK)) begin
               ev_rev   = 1'b1;
               ev_dtl   = DTL_UV;
               nxt_s.rs = RS_HICCUP;
            end else if (sin[SI_OV]) begin
               ev_rev   = 1'b1;
               ev_dtl   = DTL_OV;
               nxt_s.rs = RS_HICCUP;
            end else if (ovld_run && (c_ovld >= C_STOP)) begin
               nxt_s.rs = RS_HICCUP;
            end
            if (ovld_run && (c_ovld == C_FLAG) && !ev_rev) begin
               ev_rev = 1'b1;
               ev_dtl = DTL_ILIM;
            end
         end
         RS_HICCUP: begin
            if (c_st >= C_OFF) begin
               nxt_s.rs = RS_RUN;
            end
         end
      endcase
      if (!req || shut) begin
         nxt_s.rs = RS_OFF;
      end

      // Set wins over the read clear
      nxt_s.flags = (rd_flags ? '0 : s_ff.flags) |
                    {sin[SI_SOV], sin[SI_SUV], ev_rev};

      if (rd_stat) begin
         nxt_s.dtl_held = 1'b0;
      end
      if (ev_rev && (!s_ff.dtl_held || rd_stat)) begin
         nxt_s.dtl      = ev_dtl;
         nxt_s.dtl_held = 1'b1;
      end

      if (wr) begin
         unique case (addr)
            REG_MASK: nxt_s.mask = wdata[NFLAG-1:0];
            REG_MODE: begin
               nxt_s.mode = wdata[MODE_MSB:MODE_LSB];
               nxt_s.stby = wdata[STBY_BIT];
               nxt_s.skip = wdata[SKIP_BIT];
            end
            REG_ILIM: nxt_s.ilim = wdata[2:0];
            default: ;
         endcase
      end
      // Shutdown returns the mode and limit registers to reset values; the mask keeps its value
      if (shut) begin
         nxt_s.mode = MODE_RST;
         nxt_s.stby = 1'b0;
         nxt_s.skip = 1'b0;
         nxt_s.ilim = ILIM_RST;
      end

      nxt_s.rdata = '0;
      if (rd) begin
         unique case (addr)
            REG_FLAGS:  nxt_s.rdata = {5'h00, s_ff.flags};
            REG_MASK:   nxt_s.rdata = {5'h00, s_ff.mask};
            REG_STATUS: begin
               nxt_s.rdata[ST_OK]                 = s_ff.ok;
               nxt_s.rdata[ST_DTL_MSB:ST_DTL_LSB] = s_ff.dtl;
               nxt_s.rdata[ST_ON]                 = s_ff.sw_en;
               nxt_s.rdata[ST_DIR]                = s_ff.dir_out;
               nxt_s.rdata[ST_DISCH]              = s_ff.disch_en;
               nxt_s.rdata[ST_SHDN]               = s_ff.shdn;
            end
            REG_MODE:   nxt_s.rdata = {2'h0, s_ff.skip, s_ff.stby, s_ff.mode};
            REG_ILIM:   nxt_s.rdata = {5'h00, s_ff.ilim};
            default:    nxt_s.rdata = '0;
         endcase
      end

      nxt_s.sw_en    = (nxt_s.rs == RS_RUN);
      nxt_s.disch_en = (nxt_s.rs == RS_DISCH);
      nxt_s.dir_out  = req && !shut;
      nxt_s.ok       = (nxt_s.rs == RS_RUN) && !(ovld_run && (c_ovld >= C_FLAG));
      // Codes above the fourth setting clamp to the highest limit
      nxt_s.ilim_sel = (nxt_s.ilim > ILIM_TOP) ? ILIM_TOP[1:0] : nxt_s.ilim[1:0];
      // Skip mode is the host's duty; it is only passed on to the converter
      nxt_s.pg_oe    = nxt_s.dir_out ? (!sin[SI_UV] && !sin[SI_OV]) : input_valid;
      nxt_s.irq_oe   = |(nxt_s.flags & ~nxt_s.mask);

      if (!blinking) begin
         nxt_s.blink = 1'b1;
      end else if (c_blink == C_BLINK) begin
         nxt_s.blink = !s_ff.blink;
      end
      stat_hiz = !input_valid || s_ff.stby || (s_ff.mode <= MODE_NOCHG_MAX) ||
                 (chg_state == CHG_FAULT) || shut;
      if (stat_hiz) begin
         nxt_s.stat_oe = 1'b0;
      end else if ((chg_state == CHG_TOPOFF) || (chg_state == CHG_DONE)) begin
         nxt_s.stat_oe = 1'b1;
      end else begin
         nxt_s.stat_oe = blinking && s_ff.blink;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s_ff          <= '0;
         s_ff.rs       <= RS_OFF;
         s_ff.mask     <= MASK_RST;
         s_ff.mode     <= MODE_RST;
         s_ff.ilim     <= ILIM_RST;
         s_ff.dtl      <= DTL_NONE;
         s_ff.blink    <= 1'b1;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign rdata                       = s_ff.rdata;
   assign switching_en                = s_ff.sw_en;
   assign discharge_en                = s_ff.disch_en;
   assign current_out_dir             = s_ff.dir_out;
   assign reverse_current_limit_field = s_ff.ilim_sel;
   assign skip_disable_bit            = s_ff.skip;
   assign shutdown                    = s_ff.shdn;
   assign stat_oe                     = s_ff.stat_oe;
   assign power_good_out_n_oe         = s_ff.pg_oe;
   assign interrupt_out_n_oe          = s_ff.irq_oe;

   chk_stat_noinput: assert property (@(posedge clock) disable iff (rst)
      !input_valid |=> !stat_oe) else $error("status pin driven with no input");
   chk_stat_done_low: assert property (@(posedge clock) disable iff (rst)
      (input_valid && !s_ff.stby && s_ff.mode > MODE_NOCHG_MAX && !shut &&
       (chg_state == CHG_DONE || chg_state == CHG_TOPOFF)) |=> stat_oe)
      else $error("status pin not low when charge done");
   chk_rev_off: assert property (@(posedge clock) disable iff (rst)
      (s_ff.mode != MODE_REVERSE && !sin[SI_PIN]) |=> !switching_en)
      else $error("switching without reverse request");
   chk_detail_hold: assert property (@(posedge clock) disable iff (rst)
      (s_ff.dtl_held && !rd_stat) |=> $stable(s_ff.dtl))
      else $error("fault detail changed before read");
   chk_ovld_flag: assert property (@(posedge clock) disable iff (rst)
      (ovld_run && c_ovld == C_FLAG) |=> s_ff.flags[FLAG_REV] && !s_ff.ok)
      else $error("overload flag missing");
   chk_hiccup_off: assert property (@(posedge clock) disable iff (rst)
      (s_ff.rs == RS_RUN ##1 s_ff.rs == RS_HICCUP) |-> !switching_en [*2])
      else $error("switching during off time");
   chk_uv_detail: assert property (@(posedge clock) disable iff (rst)
      (s_ff.rs == RS_RUN && sin[SI_UV] && c_st >= C_BLANK && !s_ff.dtl_held && req && !shut)
      |=> s_ff.dtl == DTL_UV && s_ff.rs == RS_HICCUP) else $error("undervoltage fault missed");
   chk_ov_detail: assert property (@(posedge clock) disable iff (rst)
      (s_ff.rs == RS_RUN && sin[SI_OV] && !(sin[SI_UV] && c_st >= C_BLANK) &&
       !s_ff.dtl_held && req && !shut) |=> s_ff.dtl == DTL_OV)
      else $error("overvoltage fault missed");
   chk_disch_start: assert property (@(posedge clock) disable iff (rst)
      (s_ff.rs == RS_OFF && req && !shut && !sin[SI_UV]) |=> discharge_en && !switching_en)
      else $error("no discharge before start");
   chk_sysov_shdn: assert property (@(posedge clock) disable iff (rst)
      sin[SI_SOV] |=> shutdown && s_ff.flags[FLAG_SOV]) else $error("overvoltage no shutdown");
   chk_irq_pin: assert property (@(posedge clock) disable iff (rst)
      (|(s_ff.flags & ~s_ff.mask)) |-> interrupt_out_n_oe) else $error("interrupt pin idle");
   chk_flag_sticky: assert property (@(posedge clock) disable iff (rst)
      (s_ff.flags[FLAG_SUV] && !rd_flags) |=> s_ff.flags[FLAG_SUV])
      else $error("flag lost before read");
endmodule : rsfs_top

// >>> rsfs_pkg.sv
// Constants, register map and types for the reverse supply fault supervisor
package rsfs_pkg;
   // Clock and documented times in nanoseconds
   localparam int CLK_PERIOD_NS  = 40;
   localparam int OVLD_FLAG_NS   = 37_500_000;
   localparam int OVLD_STOP_NS   = 60_000_000;
   localparam int OFF_TIME_NS    = 300_000_000;
   localparam int SYS_UV_NS      = 8_000_000;
   localparam int BLINK_HALF_NS  = 500_000_000;
   localparam int START_BLANK_NS = 1_000_000;

   // Least times round up to whole cycles
   function automatic int rsfs_cyc(input int t_ns);
      return (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   endfunction : rsfs_cyc

   localparam int OVLD_FLAG_CYC   = rsfs_cyc(OVLD_FLAG_NS);
   localparam int OVLD_STOP_CYC   = rsfs_cyc(OVLD_STOP_NS);
   localparam int OFF_TIME_CYC    = rsfs_cyc(OFF_TIME_NS);
   localparam int SYS_UV_CYC      = rsfs_cyc(SYS_UV_NS);
   localparam int BLINK_HALF_CYC  = rsfs_cyc(BLINK_HALF_NS);
   localparam int START_BLANK_CYC = rsfs_cyc(START_BLANK_NS);
   localparam int CNT_W           = 24;

   // Register offsets
   localparam logic [7:0] REG_FLAGS  = 8'h00;
   localparam logic [7:0] REG_MASK   = 8'h01;
   localparam logic [7:0] REG_STATUS = 8'h02;
   localparam logic [7:0] REG_MODE   = 8'h03;
   localparam logic [7:0] REG_ILIM   = 8'h04;

   // Flag and mask bit positions
   localparam int FLAG_REV = 0;
   localparam int FLAG_SUV = 1;
   localparam int FLAG_SOV = 2;
   localparam int NFLAG    = 3;

   // Mode register fields
   localparam int MODE_LSB = 0;
   localparam int MODE_MSB = 3;
   localparam int STBY_BIT = 4;
   localparam int SKIP_BIT = 5;

   // Status register fields
   localparam int ST_OK     = 0;
   localparam int ST_DTL_LSB = 1;
   localparam int ST_DTL_MSB = 2;
   localparam int ST_ON     = 3;
   localparam int ST_DIR    = 4;
   localparam int ST_DISCH  = 5;
   localparam int ST_SHDN   = 6;

   // Reset values
   localparam logic [3:0]       MODE_RST = 4'h0;
   localparam logic [NFLAG-1:0] MASK_RST = 3'h0;
   localparam logic [2:0]       ILIM_RST = 3'h0;

   localparam logic [3:0] MODE_REVERSE  = 4'ha;
   localparam logic [3:0] MODE_NOCHG_MAX = 4'h4;
   localparam logic [2:0] ILIM_TOP      = 3'h3;

   // Fault detail codes
   localparam logic [1:0] DTL_UV   = 2'h0;
   localparam logic [1:0] DTL_ILIM = 2'h1;
   localparam logic [1:0] DTL_OV   = 2'h2;
   localparam logic [1:0] DTL_NONE = 2'h3;

   // Charger state codes on chg_state
   localparam logic [2:0] CHG_TRICKLE = 3'h1;
   localparam logic [2:0] CHG_PRECHG  = 3'h2;
   localparam logic [2:0] CHG_FAST    = 3'h3;
   localparam logic [2:0] CHG_TOPOFF  = 3'h4;
   localparam logic [2:0] CHG_DONE    = 3'h5;
   localparam logic [2:0] CHG_FAULT   = 3'h6;

   // Synchronised input positions
   localparam int SI_PIN  = 0;
   localparam int SI_OVLD = 1;
   localparam int SI_UV   = 2;
   localparam int SI_OV   = 3;
   localparam int SI_SUV  = 4;
   localparam int SI_SOV  = 5;
   localparam int SI_HOT  = 6;
   localparam int SI_COOL = 7;
   localparam int NSYNC   = 8;

   typedef enum logic [1:0] {RS_OFF, RS_DISCH, RS_RUN, RS_HICCUP} rsfs_rev_t;
endpackage : rsfs_pkg

// >>> rsfs_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module rsfs_sync #(
   parameter int W = 8
) (
   input  wire logic         clock,
   input  wire logic         rst,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } rsfs_sync_t;

   rsfs_sync_t s_ff;
   rsfs_sync_t nxt_s;

   always_comb begin
      nxt_s    = s_ff;
      nxt_s.s1 = din;
      nxt_s.s2 = s_ff.s1;
      nxt_s.s3 = s_ff.s2;
      // A change is taken only once the last two stages agree
      nxt_s.q  = (s_ff.s2 & s_ff.s3) | (s_ff.q & (s_ff.s2 ^ s_ff.s3));
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign dout = s_ff.q;
endmodule : rsfs_sync

// >>> rsfs_cnt.sv
// Saturating elapsed-time counter with synchronous clear
`timescale 1ns/1ps
module rsfs_cnt
   import rsfs_pkg::*;
(
   input  wire logic             clock,
   input  wire logic             rst,
   input  wire logic             clr,
   output logic      [CNT_W-1:0] count
);
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
   } rsfs_cnt_t;

   rsfs_cnt_t c_ff;
   rsfs_cnt_t nxt_c;

   always_comb begin
      nxt_c = c_ff;
      if (clr) begin
         nxt_c.cnt = '0;
      end else if (~&c_ff.cnt) begin
         nxt_c.cnt = c_ff.cnt + 1'b1;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         c_ff <= '0;
      end else begin
         c_ff <= nxt_c;
      end
   end

   assign count = c_ff.cnt;
endmodule : rsfs_cnt

// >>> rsfs_host.sv
// Host processor model: register bus master for the supervisor
`timescale 1ns/1ps
module rsfs_host
   import rsfs_pkg::*;
(
   input  wire logic       clock,
   output logic      [7:0] addr,
   output logic      [7:0] wdata,
   output logic            wr,
   output logic            rd
);
   initial begin
      addr = 8'h00;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
   end

   // Released lines show the inverse so stale values never pass
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
      addr <= ~a;
      wdata <= ~d;
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] a);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      addr <= ~a;
   endtask : rd_reg

   // Skip mode off before reverse, back on only once reverse is off
   task automatic rev_on;
      wr_reg(REG_MODE, 8'h20);
      wr_reg(REG_MODE, 8'h2a);
   endtask : rev_on

   task automatic rev_off;
      wr_reg(REG_MODE, 8'h20);
      wr_reg(REG_MODE, 8'h00);
   endtask : rev_off
endmodule : rsfs_host

// >>> reverse_supply_fault_supervisor_bench.sv
// Self-checking bench for the reverse supply fault supervisor
`timescale 1ns/1ps
module reverse_supply_fault_supervisor_bench
   import rsfs_pkg::*;
();
   localparam int FC = 30;
   localparam int SC = 48;
   localparam int OC = 40;
   localparam int UC = 20;
   localparam int BC = 10;
   logic       clock, rst, wr, rd, rd_seen, switching_en, discharge_en;
   logic       reverse_enable_pin, ovld_cmp, in_uv_cmp, in_ov_cmp, sys_uv_cmp;
   logic       sys_ov_cmp, die_hot_cmp, die_cool_cmp, input_valid, current_out_dir;
   logic       skip_disable_bit, shutdown, stat_oe, power_good_out_n_oe;
   logic       interrupt_out_n_oe;
   logic [7:0] addr, wdata, rdata, mv;
   logic [2:0] chg_state;
   logic [1:0] reverse_current_limit_field;
   logic [15:0] expq[$];
   int         failures, checks_done, cyc, n, c;
   wire logic [5:0] mon = {stat_oe, power_good_out_n_oe, shutdown,
                           interrupt_out_n_oe, discharge_en, switching_en};

   rsfs_top #(.P_OVLD_FLAG_CYC(FC), .P_OVLD_STOP_CYC(SC), .P_OFF_TIME_CYC(OC),
      .P_SYS_UV_CYC(UC), .P_BLINK_HALF_CYC(BC), .P_START_BLANK_CYC(20)) u_dut (
      .clock, .rst, .addr, .wdata, .wr, .rd, .rdata, .reverse_enable_pin,
      .ovld_cmp, .in_uv_cmp, .in_ov_cmp, .sys_uv_cmp, .sys_ov_cmp, .die_hot_cmp,
      .die_cool_cmp, .input_valid, .chg_state, .switching_en, .discharge_en,
      .current_out_dir, .reverse_current_limit_field, .skip_disable_bit,
      .shutdown, .stat_oe, .power_good_out_n_oe, .interrupt_out_n_oe);
   rsfs_host u_host (.clock(clock), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));

   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic close_out;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : close_out

   // Read with an expected value under a bit mask
   task automatic rx(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
      expq.push_back({e, m});
      u_host.rd_reg(a);
   endtask : rx

   task automatic wt(input int s, input logic v, input int lim);
      #1;
      n = 0;
      while (mon[s] !== v && n < lim) begin
         @(posedge clock);
         #1;
         n++;
      end
   endtask : wt

   task automatic cnt;
      repeat (4) @(posedge clock);
      c = 0;
      repeat (2 * BC) begin
         @(posedge clock);
         #1;
         c += stat_oe;
      end
   endtask : cnt

   always @(posedge clock) rd_seen <= rd;
   always @(negedge clock) begin
      logic [15:0] e;
      if (rd_seen === 1'b1) begin
         e = expq.pop_front();
         check("rdata", rdata & e[7:0], e[15:8]);
      end
   end

   // Ceiling well above the several hundred cycles the sequence needs
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         close_out();
      end
   end

   initial begin
      {reverse_enable_pin, ovld_cmp, in_uv_cmp, in_ov_cmp, sys_uv_cmp} = '0;
      {sys_ov_cmp, die_hot_cmp, input_valid, chg_state} = '0;
      die_cool_cmp = 1'b1;
      rst = 1'b1;
      mv = 8'($urandom(29578));
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      rx(REG_MASK, 8'h00, 8'h07);
      rx(REG_MODE, 8'h00, 8'h3f);
      rx(REG_ILIM, 8'h00, 8'h07);
      rx(REG_STATUS, 8'h06, 8'h7f);
      u_host.wr_reg(8'h07, 8'hff);
      rx(8'h07, 8'h00, 8'hff);
      input_valid <= 1'b1;
      u_host.wr_reg(REG_MODE, 8'h05);
      for (int s = 0; s < 8; s++) begin
         chg_state <= 3'(s);
         cnt();
         check("stat", 16'(c), (s == 4 || s == 5) ? 20 : (s > 0 && s < 4) ? 10 : 0);
      end
      for (int i = 0; i < 2; i++) begin
         u_host.wr_reg(REG_MODE, i ? 8'h04 : 8'h15);
         chg_state <= CHG_FAST;
         cnt();
         check("stat_off", 16'(c), 0);
      end
      chg_state <= 3'h0;
      check("dir_fwd", current_out_dir, 1'b0);
      u_host.rev_on();
      wt(1, 1'b1, 20);
      check("disch", {n < 20, switching_en}, 2'b10);
      in_uv_cmp <= 1'b1;
      wt(0, 1'b1, 20);
      in_uv_cmp <= 1'b0;
      check("run", {n < 20, discharge_en, current_out_dir, skip_disable_bit},
            4'b1011);
      repeat (8) @(posedge clock);
      check("pg_in", power_good_out_n_oe, 1'b1);
      for (int v = 0; v < 8; v++) begin
         u_host.wr_reg(REG_ILIM, 8'(v));
         repeat (2) @(posedge clock);
         check("ilim", reverse_current_limit_field, (v > 3) ? 2'h3 : 2'(v));
         rx(REG_ILIM, 8'(v), 8'h07);
      end
      ovld_cmp <= 1'b1;
      wt(2, 1'b1, 60);
      check("ovld_flag", {n >= FC - 1 && n <= FC + 6, switching_en}, 2'b11);
      wt(0, 1'b0, 40);
      check("ovld_stop", n >= SC - FC - 3 && n <= SC - FC + 2, 1'b1);
      wt(0, 1'b1, 60);
      check("ovld_off", n >= OC - 2 && n <= OC + 2, 1'b1);
      wt(0, 1'b0, 60);
      check("ovld_rpt", n >= SC - 2 && n <= SC + 2, 1'b1);
      ovld_cmp <= 1'b0;
      wt(0, 1'b1, 60);
      rx(REG_STATUS, 8'h02, 8'h06);
      rx(REG_FLAGS, 8'h01, 8'h07);
      rx(REG_FLAGS, 8'h00, 8'h07);
      repeat (2) @(posedge clock);
      check("irq_clr", interrupt_out_n_oe, 1'b0);
      mv = mv | 8'h01;
      u_host.wr_reg(REG_MASK, mv);
      rx(REG_MASK, mv & 8'h07, 8'h07);
      in_uv_cmp <= 1'b1;
      wt(0, 1'b0, 12);
      check("uv_stop", {n < 12, interrupt_out_n_oe}, 2'b10);
      rx(REG_STATUS, 8'h00, 8'h06);
      wt(0, 1'b1, 60);
      in_uv_cmp <= 1'b0;
      check("uv_retry", n >= OC - 8 && n <= OC + 2, 1'b1);
      rx(REG_FLAGS, 8'h01, 8'h01);
      u_host.wr_reg(REG_MASK, 8'h00);
      in_ov_cmp <= 1'b1;
      wt(0, 1'b0, 12);
      repeat (2) @(posedge clock);
      check("ov_stop", {n < 12, power_good_out_n_oe, interrupt_out_n_oe}, 3'b101);
      rx(REG_STATUS, 8'h04, 8'h06);
      in_ov_cmp <= 1'b0;
      wt(0, 1'b1, 60);
      check("ov_retry", n >= OC - 12 && n <= OC + 2, 1'b1);
      in_uv_cmp <= 1'b1;
      wt(0, 1'b1, 20);
      in_uv_cmp <= 1'b0;
      rx(REG_FLAGS, 8'h01, 8'h01);
      u_host.wr_reg(REG_MODE, 8'h20);
      wt(0, 1'b0, 10);
      check("rev_off", {n < 10, current_out_dir}, 2'b10);
      reverse_enable_pin <= 1'b1;
      wt(1, 1'b1, 20);
      check("pin_on", n < 20, 1'b1);
      reverse_enable_pin <= 1'b0;
      u_host.rev_off();
      u_host.wr_reg(REG_MODE, 8'h05);
      chg_state <= CHG_FAST;
      sys_ov_cmp <= 1'b1;
      wt(3, 1'b1, 12);
      check("sov", n < 12, 1'b1);
      rx(REG_MODE, 8'h00, 8'h3f);
      cnt();
      check("stat_shdn", 16'(c), 0);
      sys_ov_cmp <= 1'b0;
      // Read only once the condition is gone, else the level flag sets again
      wt(3, 1'b0, 12);
      rx(REG_FLAGS, 8'h04, 8'h04);
      sys_uv_cmp <= 1'b1;
      wt(2, 1'b1, 12);
      check("suv_flag", {n < 12, shutdown}, 2'b10);
      wt(3, 1'b1, 40);
      check("suv_shdn", n >= UC - 5 && n <= UC + 1, 1'b1);
      sys_uv_cmp <= 1'b0;
      wt(3, 1'b0, 12);
      rx(REG_FLAGS, 8'h02, 8'h02);
      die_cool_cmp <= 1'b0;
      die_hot_cmp <= 1'b1;
      wt(3, 1'b1, 12);
      die_hot_cmp <= 1'b0;
      repeat (10) @(posedge clock);
      check("hot_hold", {n < 12, shutdown}, 2'b11);
      die_cool_cmp <= 1'b1;
      wt(3, 1'b0, 12);
      check("cool", n < 12, 1'b1);
      repeat (4) @(posedge clock);
      close_out();
   end
endmodule : reverse_supply_fault_supervisor_bench
